// >>> hdl/itmt_timer.sv
/*
  Interval timer with command word, diagnostic readout and a companion
  missed-event timer that retriggers it when no arrival pulse comes.
  Assumes command and preset writes are synchronous to clock; the
  arrival pulse comes from a pin and is synchronised here.
*/
`timescale 1ns/1ps
`include "itmt_map.svh"

module itmt_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Host command and preset writes
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        preset_wr,
  input  wire logic [15:0] preset_data,
  input  wire logic        mit_preset_wr,
  input  wire logic [7:0]  mit_preset_data,
  // Host readout
  output logic      [15:0] read_data,
  // Arrival pulse from the receiver pin
  input  wire logic        arrival_time_pulse,
  // Event outputs
  output logic             early_pulse,
  output logic             timeout_irq,
  output logic             purge_pulse
);

  function automatic itmt_pkg::itmt_act_s decode_act(input logic [15:0] w);
    itmt_pkg::itmt_act_s a;
    a.clear = w[`ITMT_BIT_ARRIVAL];
    a.read  = w[`ITMT_BIT_STOP_OVF];
    a.load  = w[`ITMT_BIT_OVF_LOAD];
    return a;
  endfunction

  itmt_pkg::itmt_mode_s mode_q, mode_d;
  itmt_pkg::itmt_cond_s cond_q, cond_d;
  itmt_pkg::itmt_act_s  act_q,  act_d;
  logic [15:0]          preset_q, preset_d;
  logic [15:0]          out_q, out_d;

  // Command decode and mode registers
  always_comb begin
    mode_d   = mode_q;
    cond_d   = cond_q;
    act_d    = '0;
    preset_d = preset_wr ? preset_data : preset_q;
    if (cmd_valid) begin
      mode_d.gate = cmd_word[`ITMT_BIT_GATE];
      mode_d.sel  = cmd_word[`ITMT_BIT_SEL];
      if (cmd_word[`ITMT_BIT_STEER]) begin
        act_d = decode_act(cmd_word);
      end else begin
        cond_d.on_timeout = cmd_word[`ITMT_BIT_ON_TIMEOUT];
        cond_d.ovf_load   = cmd_word[`ITMT_BIT_OVF_LOAD];
        cond_d.on_arrival = cmd_word[`ITMT_BIT_ARRIVAL];
        cond_d.stop_ovf   = cmd_word[`ITMT_BIT_STOP_OVF];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= '0;
      cond_q   <= '0;
      act_q    <= '0;
      preset_q <= `ITMT_CNT_ZERO;
    end else begin
      mode_q   <= mode_d;
      cond_q   <= cond_d;
      act_q    <= act_d;
      preset_q <= preset_d;
    end
  end

  // Arrival pin synchroniser and edge detect
  logic arr_m_q, arr_s_q, arr_p_q;
  logic arrival;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arr_m_q <= 1'b0;
      arr_s_q <= 1'b0;
      arr_p_q <= 1'b0;
    end else begin
      arr_m_q <= arrival_time_pulse;
      arr_s_q <= arr_m_q;
      arr_p_q <= arr_s_q;
    end
  end
  assign arrival = arr_s_q & ~arr_p_q;

  // Microsecond tick; the 250 MHz clock stands in for the system clock
  logic [7:0] pre_q, pre_d;
  logic       tick;
  assign tick = (pre_q == 8'(`ITMT_TICK_DIV - 1));
  always_comb begin
    pre_d = tick ? `ITMT_PRE_ZERO : pre_q + 8'h01;
  end

  // Interval counter
  logic [15:0] cnt_q, cnt_d;
  logic        halt_q, halt_d;
  logic        early_q, early_d;
  logic        ovf, any_load, retrig;
  assign ovf      = tick && mode_q.gate && !halt_q && (cnt_q == `ITMT_CNT_MAX);
  assign any_load = act_q.load
                  || (cond_q.on_arrival && arrival)
                  || (cond_q.on_timeout && retrig);
  always_comb begin
    cnt_d   = cnt_q;
    halt_d  = halt_q;
    early_d = ovf;
    out_d   = out_q;
    if (act_q.read) begin
      out_d = mode_q.sel ? cnt_q : preset_q;
    end
    if (act_q.clear) begin
      cnt_d  = `ITMT_CNT_ZERO;
      halt_d = 1'b0;
    end else if (any_load) begin
      cnt_d  = preset_q;
      halt_d = 1'b0;
    end else if (ovf) begin
      if (cond_q.ovf_load) begin
        cnt_d = preset_q;
      end else if (cond_q.stop_ovf) begin
        halt_d = 1'b1;
      end else begin
        cnt_d = `ITMT_CNT_ZERO;
      end
    end else if (tick && mode_q.gate && !halt_q) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q   <= `ITMT_PRE_ZERO;
      cnt_q   <= `ITMT_CNT_ZERO;
      halt_q  <= 1'b0;
      early_q <= 1'b0;
      out_q   <= `ITMT_CNT_ZERO;
    end else begin
      pre_q   <= pre_d;
      cnt_q   <= cnt_d;
      halt_q  <= halt_d;
      early_q <= early_d;
      out_q   <= out_d;
    end
  end

  // Missed-event timer
  itmt_pkg::itmt_mit_e mit_st_q, mit_st_d;
  logic [7:0] mit_pre_q, mit_pre_d;
  logic [7:0] mit_cnt_q, mit_cnt_d;
  logic       tout_q, tout_d;
  logic       expire;
  assign expire = (mit_st_q == itmt_pkg::ITMT_MIT_RUN) && tick
               && (mit_cnt_q == `ITMT_MIT_MAX) && !arrival;
  assign retrig = tout_q;
  always_comb begin
    mit_st_d  = mit_st_q;
    mit_cnt_d = mit_cnt_q;
    mit_pre_d = mit_preset_wr ? mit_preset_data : mit_pre_q;
    tout_d    = 1'b0;
    unique case (mit_st_q)
      itmt_pkg::ITMT_MIT_IDLE: begin
        if (early_q) begin
          mit_st_d  = itmt_pkg::ITMT_MIT_RUN;
          mit_cnt_d = mit_pre_q;
        end
      end
      itmt_pkg::ITMT_MIT_RUN: begin
        if (arrival) begin
          mit_st_d = itmt_pkg::ITMT_MIT_IDLE;
        end else if (expire) begin
          mit_st_d = itmt_pkg::ITMT_MIT_IDLE;
          tout_d   = 1'b1;
        end else if (tick) begin
          mit_cnt_d = mit_cnt_q + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mit_st_q  <= itmt_pkg::ITMT_MIT_IDLE;
      mit_pre_q <= `ITMT_MIT_ZERO;
      mit_cnt_q <= `ITMT_MIT_ZERO;
      tout_q    <= 1'b0;
    end else begin
      mit_st_q  <= mit_st_d;
      mit_pre_q <= mit_pre_d;
      mit_cnt_q <= mit_cnt_d;
      tout_q    <= tout_d;
    end
  end

  // Timeout drives interrupt and purge together; retrigger loads next cycle
  assign read_data   = out_q;
  assign early_pulse = early_q;
  assign timeout_irq = tout_q;
  assign purge_pulse = tout_q;

  // Checks
  sequence s_mit_expire;
    expire;
  endsequence

  sequence s_single_pulse;
    timeout_irq ##1 !timeout_irq;
  endsequence

  property p_clear_zero;
    @(posedge clock) disable iff (!rst_n)
      act_q.clear |=> cnt_q == `ITMT_CNT_ZERO;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero");

  property p_prog_load;
    @(posedge clock) disable iff (!rst_n)
      act_q.load && !act_q.clear |=> cnt_q == $past(preset_q);
  endproperty
  a_prog_load: assert property (p_prog_load) else $error("program load missed");

  property p_read_cap;
    @(posedge clock) disable iff (!rst_n)
      act_q.read |=> out_q == ($past(mode_q.sel) ? $past(cnt_q) : $past(preset_q));
  endproperty
  a_read_cap: assert property (p_read_cap) else $error("readout wrong source");

  property p_cond_hold;
    @(posedge clock) disable iff (!rst_n)
      cmd_valid && cmd_word[`ITMT_BIT_STEER] |=> $stable(cond_q);
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("modes changed on steer");

  property p_mode_upd;
    @(posedge clock) disable iff (!rst_n)
      cmd_valid |=> mode_q.gate == $past(cmd_word[`ITMT_BIT_GATE]);
  endproperty
  a_mode_upd: assert property (p_mode_upd) else $error("gate not updated");

  property p_act_idle;
    @(posedge clock) disable iff (!rst_n)
      act_q.load && !cmd_valid |=> !act_q.load;
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("action stuck");

  property p_freeze;
    @(posedge clock) disable iff (!rst_n)
      !mode_q.gate && !any_load && !act_q.clear |=> $stable(cnt_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen counter moved");

  property p_timeout_once;
    @(posedge clock) disable iff (!rst_n)
      $rose(timeout_irq) |-> s_single_pulse;
  endproperty
  a_timeout_once: assert property (p_timeout_once) else $error("timeout width");

  property p_expire_out;
    @(posedge clock) disable iff (!rst_n)
      s_mit_expire |=> timeout_irq && purge_pulse ##1 cnt_q == $past(cnt_q)
        || cond_q.on_timeout;
  endproperty
  a_expire_out: assert property (p_expire_out) else $error("timeout not issued");

  property p_arr_suppress;
    @(posedge clock) disable iff (!rst_n)
      mit_st_q == itmt_pkg::ITMT_MIT_RUN && arrival |=> !timeout_irq [*2];
  endproperty
  a_arr_suppress: assert property (p_arr_suppress) else $error("timeout not suppressed");

  property p_stop_ovf;
    @(posedge clock) disable iff (!rst_n)
      ovf && cond_q.stop_ovf && !cond_q.ovf_load && !any_load && !act_q.clear
        |=> halt_q && early_pulse;
  endproperty
  a_stop_ovf: assert property (p_stop_ovf) else $error("no halt on overflow");

  property p_arrival_load;
    @(posedge clock) disable iff (!rst_n)
      cond_q.on_arrival && arrival && !act_q.clear |=> cnt_q == $past(preset_q);
  endproperty
  a_arrival_load: assert property (p_arrival_load) else $error("no arrival load");

  property p_ovf_load;
    @(posedge clock) disable iff (!rst_n)
      ovf && cond_q.ovf_load && !any_load && !act_q.clear |=> cnt_q == $past(preset_q);
  endproperty
  a_ovf_load: assert property (p_ovf_load) else $error("no overflow load");

  // Start is a separate step so a stuck idle state is caught at the early pulse
  sequence s_mit_start;
    mit_st_q == itmt_pkg::ITMT_MIT_IDLE && early_q;
  endsequence

  property p_mit_start;
    @(posedge clock) disable iff (!rst_n)
      s_mit_start |=> mit_st_q == itmt_pkg::ITMT_MIT_RUN && mit_cnt_q == $past(mit_pre_q);
  endproperty
  a_mit_start: assert property (p_mit_start) else $error("missed timer not started");

endmodule

// >>> include/itmt_map.svh
/*
  Constants for the interval timer with missed-event timeout: command
  word bit positions, widths, reset values and tick timing.
  Assumes a single 250 MHz clock and a 1 MHz counting tick made from it.
*/
// Behaviour
// - Bit 10 steers bits 7, 11-13 meaning
// - Steer low, bit 12: interrupt arrivals load preset
// - Steer low, bit 11: overflow loads preset
// - Steer high, bit 11: load preset now
// - Steer high, bit 12: clear counter anytime
// - Steer low, bit 13: stop on overflow
// - Steer high, bit 13: capture readout register
// - Bit 14 selects input or counter
// - Bit 15 gates counting, zero freezes
// - Gate and select update every command
// - Conditional modes update only steering low
// - Actions pulse only when steering high
// - Action generators self-return to idle
// - Overflow pulse is the early warning
// - Missed timer: 8-bit counter and preset
// - Early pulse starts missed timer counting
// - Missed timeout pulse one clock wide
// - Arrival pulse suppresses missed timeout
// - Timeout interrupts, purges, retriggers timer
// - 16-bit counter and preset at 1 MHz
// - Timing derived from the system clock
// - Overflow with stop halts, early pulse out
`ifndef ITMT_MAP_SVH
`define ITMT_MAP_SVH

`define ITMT_BIT_ON_TIMEOUT 7
`define ITMT_BIT_STEER      10
`define ITMT_BIT_OVF_LOAD   11
`define ITMT_BIT_ARRIVAL    12
`define ITMT_BIT_STOP_OVF   13
`define ITMT_BIT_SEL        14
`define ITMT_BIT_GATE       15

`define ITMT_CNT_ZERO  16'h0000
`define ITMT_CNT_MAX   16'hFFFF
`define ITMT_MIT_ZERO  8'h00
`define ITMT_MIT_MAX   8'hFF
`define ITMT_PRE_ZERO  8'h00

`define ITMT_CLK_NS    4
`define ITMT_TICK_NS   1000
`define ITMT_TICK_DIV  (`ITMT_TICK_NS / `ITMT_CLK_NS)
`define ITMT_EARLY_US  56

`endif

// >>> include/itmt_pkg.sv
/*
  Types for the interval timer block: mode groups, action pulses and
  missed-event timer states.
  Assumes itmt_map.svh is included by the design file.
*/
package itmt_pkg;

  typedef struct packed {
    logic gate;
    logic sel;
  } itmt_mode_s;

  typedef struct packed {
    logic on_timeout;
    logic ovf_load;
    logic on_arrival;
    logic stop_ovf;
  } itmt_cond_s;

  typedef struct packed {
    logic clear;
    logic read;
    logic load;
  } itmt_act_s;

  typedef enum logic [0:0] {
    ITMT_MIT_IDLE,
    ITMT_MIT_RUN
  } itmt_mit_e;

endpackage

// >>> test/itmt_rcvr_model.sv
/*
  Receiver model: answers each early warning with an arrival pulse.
  Assumes it sees early_pulse from the timer and an answer enable from the bench.
*/
`timescale 1ns/1ps

module itmt_rcvr_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic early_pulse,
  input  wire logic answer_en,
  // Receiver pin, driven low between pulses
  output logic      arrival_time_pulse
);
  int cnt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (early_pulse && answer_en) begin
      cnt <= 100;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // Held 4 clocks so the two-stage synchroniser cannot miss it
  assign arrival_time_pulse = (cnt > 0) && (cnt < 5);
endmodule

// >>> test/interval_timer_with_missed_timeout_tb_top.sv
/*
  Self-checking bench for the interval timer and missed-event timer.
  Assumes the receiver model answers early warnings while answer_en is high.
*/
`timescale 1ns/1ps

module interval_timer_with_missed_timeout_tb_top;
  logic        clock;
  logic        rst_n;
  logic        cmd_valid;
  logic [15:0] cmd_word;
  logic        preset_wr;
  logic [15:0] preset_data;
  logic        mit_preset_wr;
  logic [7:0]  mit_preset_data;
  logic [15:0] read_data;
  logic        arrival_time_pulse;
  logic        early_pulse;
  logic        timeout_irq;
  logic        purge_pulse;
  logic        answer_en;
  logic        prev_tmo;
  logic [31:0] seed;
  logic [15:0] pre;
  int          failures;
  int          checks_done;
  int          tmo;
  int          n;

  itmt_timer itmt_timer_i (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .preset_wr(preset_wr), .preset_data(preset_data), .mit_preset_wr(mit_preset_wr),
    .mit_preset_data(mit_preset_data), .read_data(read_data),
    .arrival_time_pulse(arrival_time_pulse), .early_pulse(early_pulse),
    .timeout_irq(timeout_irq), .purge_pulse(purge_pulse));

  itmt_rcvr_model itmt_rcvr_model_i (
    .clock(clock), .rst_n(rst_n), .early_pulse(early_pulse), .answer_en(answer_en),
    .arrival_time_pulse(arrival_time_pulse));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [15:0] w);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] w, input logic [15:0] exp);
    cmd(w);
    repeat (2) @(posedge clock);
    #1 chk(read_data, exp);
  endtask

  task automatic wpre(input logic [15:0] v);
    @(posedge clock);
    preset_wr   <= 1'b1;
    preset_data <= v;
    @(posedge clock);
    preset_wr <= 1'b0;
  endtask

  // Cycles until the chosen event, capped so a silent design cannot hang;
  // sampled mid-cycle, returns on a rising edge so later drives stay aligned
  task automatic wait_ev(input bit which, output int c);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while ((which ? timeout_irq : early_pulse) !== 1'b1 && c < 3000);
    @(posedge clock);
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(negedge clock) begin
    if (rst_n) begin
      chk({15'h0000, timeout_irq}, {15'h0000, purge_pulse});
      chk({15'h0000, timeout_irq & prev_tmo}, 16'h0000);
      if (timeout_irq === 1'b1) tmo++;
    end
    prev_tmo = timeout_irq;
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    preset_wr = 1'b0;
    preset_data = 16'h0000;
    mit_preset_wr = 1'b0;
    mit_preset_data = 8'h00;
    answer_en = 1'b0;
    prev_tmo = 1'b0;
    seed = 32'hD310;
    failures = 0;
    checks_done = 0;
    tmo = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // Random presets through input register, clear and program load, gate off
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pre = seed[15:0];
      wpre(pre);
      rd(16'h2400, pre);
      cmd(16'h1400);
      rd(16'h6400, 16'h0000);
      cmd(16'h0C00);
      rd(16'h6400, pre);
    end
    // Missed timer preset gives 3 ticks to timeout
    @(posedge clock);
    mit_preset_wr   <= 1'b1;
    mit_preset_data <= 8'hFD;
    @(posedge clock);
    mit_preset_wr <= 1'b0;
    answer_en <= 1'b1;
    wpre(16'hFFFC);
    cmd(16'h8800);
    cmd(16'h8C00);
    wait_ev(1'b0, n);
    chk({15'h0000, n < 3000}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      wait_ev(1'b0, n);
      chk(n[15:0], 16'h03E8);
    end
    chk(tmo[15:0], 16'h0000);
    // Receiver silent: timeout follows the early warning
    answer_en <= 1'b0;
    wait_ev(1'b0, n);
    chk({15'h0000, n < 3000}, 16'h0001);
    wait_ev(1'b1, n);
    chk({15'h0000, n >= 500 && n <= 752}, 16'h0001);
    // Timeout retriggers the interval count when bit 7 mode is set
    cmd(16'h8880);
    wait_ev(1'b1, n);
    chk({15'h0000, n < 3000}, 16'h0001);
    wait_ev(1'b0, n);
    chk({15'h0000, n >= 995 && n <= 1002}, 16'h0001);
    // Stop on overflow survives a steer-high start command
    cmd(16'hA000);
    cmd(16'h8C00);
    wait_ev(1'b0, n);
    chk({15'h0000, n < 3000}, 16'h0001);
    repeat (600) @(posedge clock);
    rd(16'hE400, 16'hFFFF);
    wait_ev(1'b0, n);
    chk(n[15:0], 16'h0BB8);
    // Arrival reload restarts the halted counter, so warnings keep coming
    answer_en <= 1'b1;
    cmd(16'hB000);
    cmd(16'h8C00);
    wait_ev(1'b0, n);
    chk({15'h0000, n < 3000}, 16'h0001);
    wait_ev(1'b0, n);
    chk(n[15:0], 16'h03E8);
    end_sim();
  end
endmodule
